/* logic/dbdcr_pkg.sv */
// dbdcr_pkg: register map, field layout, reset values and timing constants
// of the dual bridge driver configuration bank.
// assumes nothing outside; imported by every design file of the block.
package dbdcr_pkg;

   // ---------------------------------------------------------------
   // frame and register geometry
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W  = 12;   // data bits per register
   localparam int unsigned ADDR_W  = 3;    // address bits per frame
   localparam int unsigned FRAME_W = 16;   // whole serial frame
   localparam int unsigned FRAME_CNT_W = 5;

   // register indices
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_TORQUE  = 3'h1;
   localparam logic [2:0] ADDR_OFFTIME = 3'h2;
   localparam logic [2:0] ADDR_BLANK   = 3'h3;
   localparam logic [2:0] ADDR_DECAY   = 3'h4;
   localparam logic [2:0] ADDR_SPARE   = 3'h5;
   localparam logic [2:0] ADDR_DRIVE   = 3'h6;
   localparam logic [2:0] ADDR_FAULTS  = 3'h7;

   // writable bit masks; everything else is reserved and reads zero
   localparam logic [11:0] MASK_CONTROL = 12'hf01;
   localparam logic [11:0] MASK_TORQUE  = 12'h0ff;
   localparam logic [11:0] MASK_OFFTIME = 12'h1ff;
   localparam logic [11:0] MASK_BLANK   = 12'h0ff;
   localparam logic [11:0] MASK_DECAY   = 12'h7ff;
   localparam logic [11:0] MASK_DRIVE   = 12'hfff;

   // reset values
   localparam logic [11:0] RST_CONTROL = 12'h301; // gain 11, enable 1
   localparam logic [11:0] RST_TORQUE  = 12'h0ff;
   localparam logic [11:0] RST_OFFTIME = 12'h130; // pwm mode 1, 0x30
   localparam logic [11:0] RST_BLANK   = 12'h080;
   localparam logic [11:0] RST_DECAY   = 12'h010; // slow decay, 0x10
   localparam logic [11:0] RST_DRIVE   = 12'hfa5;

   // field positions
   localparam int unsigned BIT_ENABLE   = 0;
   localparam int unsigned BIT_OTS      = 0;
   localparam int unsigned BIT_OCP_A    = 1;
   localparam int unsigned BIT_OCP_B    = 2;
   localparam int unsigned BIT_PDF_A    = 3;
   localparam int unsigned BIT_PDF_B    = 4;
   localparam int unsigned BIT_UV       = 5;

   // decay mode codes
   localparam logic [2:0] DECAY_SLOW  = 3'h0;
   localparam logic [2:0] DECAY_FAST  = 3'h2;
   localparam logic [2:0] DECAY_MIXED = 3'h3;
   localparam logic [2:0] DECAY_AUTO  = 3'h5;

   // timing: system clock and step sizes in picoseconds
   localparam int unsigned CLK_PERIOD_PS = 20000;  // 50 MHz
   localparam int unsigned OFF_STEP_PS   = 525000;
   localparam int unsigned OFF_STEP_CYC  = OFF_STEP_PS / CLK_PERIOD_PS;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      DBDCR_IDLE  = 2'b00,
      DBDCR_SHIFT = 2'b01,
      DBDCR_DONE  = 2'b10
   } dbdcr_frame_t;

   // one decoded frame handed from the serial front end
   typedef struct packed {
      logic        valid;   // one-cycle strobe
      logic        isRead;
      logic [2:0]  addr;
      logic [11:0] data;
   } dbdcr_frame_req_t;

   // raw fault events from the analog protection circuits
   typedef struct packed {
      logic overTemp;
      logic ocpA;
      logic ocpB;
      logic pdfA;
      logic pdfB;
      logic underVolt;
   } dbdcr_faults_t;

   // configuration seen by the analog side
   typedef struct packed {
      logic [1:0] senseGainSel;
      logic [1:0] deadTimeSel;
      logic [7:0] torque;
      logic [7:0] offTimeVal;
      logic       controlModeBit;
      logic [7:0] blankTimeVal;
      logic [7:0] decayTransitionVal;
      logic [2:0] decayModeSel;
      logic [1:0] overcurrentThreshold;
      logic [1:0] overcurrentDeglitch;
      logic [1:0] gateSinkTime;
      logic [1:0] gateSourceTime;
      logic [1:0] gateSinkCurrent;
      logic [1:0] gateSourceCurrent;
   } dbdcr_cfg_t;

endpackage

/* logic/dbdcr_serial_rx.sv */
// dbdcr_serial_rx: serial front end; samples the link clock and chip
// select with mclk, shifts sixteen bits, drives serial_data_out.
// assumes the link clock is far slower than mclk (160 ns vs 20 ns).
`timescale 1ns/10ps
`default_nettype none
module dbdcr_serial_rx
   import dbdcr_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              active,     // low while asleep
   // link pins
   input  wire logic              sclk,
   input  wire logic              scs,
   input  wire logic              serialDataIn,
   output logic                   serialDataOut,
   // register side
   output dbdcr_frame_req_t       frameReq,
   input  wire logic [DATA_W-1:0] readData,
   output logic [ADDR_W-1:0]      rdAddr
);
   typedef struct packed {
      logic [1:0]             sclkSync;   // two-flop synchroniser
      logic                   sclkOld;
      logic [1:0]             scsSync;
      logic                   scsOld;
      logic [1:0]             sdiSync;
      logic [FRAME_CNT_W-1:0] bitCount;
      logic [FRAME_W-1:0]     shiftIn;
      logic [DATA_W-1:0]      shiftOut;
      logic                   sdo;
      dbdcr_frame_req_t       req;
   } rx_state_t;

   rx_state_t st_q;
   rx_state_t st_d;
   logic      rise;
   logic      fall;
   logic      scsHi;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.req.valid = 1'b0;
      st_d.sclkSync = {st_q.sclkSync[0], sclk};
      st_d.scsSync  = {st_q.scsSync[0], scs};
      st_d.sdiSync  = {st_q.sdiSync[0], serialDataIn};
      st_d.sclkOld  = st_q.sclkSync[1];
      st_d.scsOld   = st_q.scsSync[1];
      rise  = st_q.sclkSync[1] & ~st_q.sclkOld;
      fall  = ~st_q.sclkSync[1] & st_q.sclkOld;
      scsHi = st_q.scsSync[1];
      if (!active) begin
         // asleep: frames are ignored and the output stays low
         st_d.bitCount = '0;
         st_d.sdo      = 1'b0;
      end else if (!scsHi) begin
         // chip select low ends the frame
         if (st_q.scsOld && st_q.bitCount == FRAME_CNT_W'(FRAME_W)) begin
            st_d.req.valid  = 1'b1;
            st_d.req.isRead = st_q.shiftIn[FRAME_W-1];
            st_d.req.addr   = st_q.shiftIn[FRAME_W-2 -: ADDR_W];
            st_d.req.data   = st_q.shiftIn[DATA_W-1:0];
         end
         st_d.bitCount = '0;
         st_d.sdo      = 1'b0;
      end else begin
         if (rise && st_q.bitCount < FRAME_CNT_W'(FRAME_W)) begin
            st_d.shiftIn  = {st_q.shiftIn[FRAME_W-2:0], st_q.sdiSync[1]};
            st_d.bitCount = st_q.bitCount + 1'b1;
         end
         // read data is loaded once the address is
         if (fall && st_q.bitCount == FRAME_CNT_W'(1 + ADDR_W)) begin
            st_d.sdo      = readData[DATA_W-1];
            st_d.shiftOut = {readData[DATA_W-2:0], 1'b0};
         end else if (fall && st_q.bitCount > FRAME_CNT_W'(1 + ADDR_W)) begin
            st_d.sdo      = st_q.shiftOut[DATA_W-1];
            st_d.shiftOut = {st_q.shiftOut[DATA_W-2:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // address bits for read-data lookup come straight from the shifter
   assign rdAddr        = st_q.shiftIn[ADDR_W-1:0];
   assign frameReq      = st_q.req;
   assign serialDataOut = st_q.sdo;
endmodule
`default_nettype wire

/* logic/dbdcr_regs.sv */
// dbdcr_regs: register bank of the dual bridge driver configuration.
// Contract
// - active while sleep input high, asleep low
// - sleep disables pump, bridges, regulator, serial
// - wake automatically when sleep input rises
// - enable bit zero disables both bridges
// - any fault disables affected bridge outputs
// - reset loads every register default
// - sense gain field bits nine to eight
// - dead time field bits eleven to ten
// - torque byte scales both bridges, resets ones
// - off time field, default 0x30
// - blanking field sets blank, min on-time
// - decay transition byte, default 0x10
// - decay mode select, reserved codes exist
// - gate sink time at bits five-four
// - gate source time at bits seven-six
// - gate sink current at bits nine-eight
// - gate source current at bits eleven-ten
// - overtemp flag follows condition, read-only
// - overcurrent flags latch, host clears
// - predriver flags latch until written zero
// - undervoltage flag follows, sleep clear ignored
// - sixteen bit frame ends at select low
// - read uses address, shifts data out
// assumes fault inputs come from analog detectors on the mclk domain;
// link pins come from outside and are synchronised in the front end.
`timescale 1ns/10ps
`default_nettype none
module dbdcr_regs
   import dbdcr_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // sleep pin
   input  wire logic          sleep_n_input,
   // serial link pins
   input  wire logic          sclk,
   input  wire logic          scs,
   input  wire logic          serial_data_in,
   output logic               serial_data_out,
   output logic               serial_data_out_oe,
   // fault detectors
   input  wire dbdcr_faults_t faultIn,
   // power and bridge controls
   output logic               chargePumpEn,
   output logic               five_volt_regulator_en,
   output logic               bridgeAEn,
   output logic               bridgeBEn,
   output logic               faultPending_n,
   // configuration fields
   output dbdcr_cfg_t         cfg,
   output logic               decayModeReserved
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  sleepSync;    // pin synchroniser
      logic [11:0] control;
      logic [11:0] torque;
      logic [11:0] offTime;
      logic [11:0] blank;
      logic [11:0] decay;
      logic [11:0] drive;
      logic        overTemp;
      logic        ocpA;
      logic        ocpB;
      logic        pdfA;
      logic        pdfB;
      logic        underVolt;
      logic        pumpEn;
      logic        regEn;
      logic        bridgeA;
      logic        bridgeB;
      logic        faultN;
   } regs_state_t;

   regs_state_t      st_q;
   regs_state_t      st_d;
   dbdcr_frame_req_t req;
   logic [11:0]      readData;
   logic [2:0]       rdAddr;       // live address from the shifter
   logic [11:0]      statusWord;
   logic             active;
   logic             wr;

   // masked write helper shared by all config registers
   function automatic logic [11:0] mwrite(input logic [11:0] mask,
                                          input logic [11:0] val);
      mwrite = val & mask;
   endfunction

   // ---------------------------------------------------------------
   // serial front end
   // ---------------------------------------------------------------
   dbdcr_serial_rx u_rx (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .active        (active),
      .sclk          (sclk),
      .scs           (scs),
      .serialDataIn  (serial_data_in),
      .serialDataOut (serial_data_out),
      .frameReq      (req),
      .readData      (readData),
      .rdAddr        (rdAddr)
   );

   // sleep pin after two flops; low means asleep
   assign active = st_q.sleepSync[1];

   // live status word; reserved upper bits read zero
   always_comb begin
      statusWord = '0;
      statusWord[BIT_OTS]   = st_q.overTemp;
      statusWord[BIT_OCP_A] = st_q.ocpA;
      statusWord[BIT_OCP_B] = st_q.ocpB;
      statusWord[BIT_PDF_A] = st_q.pdfA;
      statusWord[BIT_PDF_B] = st_q.pdfB;
      statusWord[BIT_UV]    = st_q.underVolt;
   end

   // ---------------------------------------------------------------
   // read mux; address is taken from the shift register live, so
   // the front end gets the word in the bit slot after the address
   // ---------------------------------------------------------------
   always_comb begin
      case (rdAddr)
         ADDR_CONTROL: readData = st_q.control;
         ADDR_TORQUE:  readData = st_q.torque;
         ADDR_OFFTIME: readData = st_q.offTime;
         ADDR_BLANK:   readData = st_q.blank;
         ADDR_DECAY:   readData = st_q.decay;
         ADDR_DRIVE:   readData = st_q.drive;
         ADDR_FAULTS:  readData = statusWord;
         default:      readData = '0; // spare slot reads zero
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.sleepSync = {st_q.sleepSync[0], sleep_n_input};
      // a frame writes when its first bit is zero
      wr = req.valid & ~req.isRead & active;
      if (wr) begin
         case (req.addr)
            ADDR_CONTROL: st_d.control = mwrite(MASK_CONTROL, req.data);
            ADDR_TORQUE:  st_d.torque  = mwrite(MASK_TORQUE, req.data);
            ADDR_OFFTIME: st_d.offTime = mwrite(MASK_OFFTIME, req.data);
            ADDR_BLANK:   st_d.blank   = mwrite(MASK_BLANK, req.data);
            ADDR_DECAY:   st_d.decay   = mwrite(MASK_DECAY, req.data);
            ADDR_DRIVE:   st_d.drive   = mwrite(MASK_DRIVE, req.data);
            ADDR_FAULTS: begin
               // writing zero clears a latched flag; an event in the
               // same cycle wins over the clear
               if (!req.data[BIT_OCP_A]) st_d.ocpA = 1'b0;
               if (!req.data[BIT_OCP_B]) st_d.ocpB = 1'b0;
               if (!req.data[BIT_PDF_A]) st_d.pdfA = 1'b0;
               if (!req.data[BIT_PDF_B]) st_d.pdfB = 1'b0;
            end
            default: begin
               // spare slot: write has no effect
            end
         endcase
      end
      // latched faults; set wins over the clear
      if (faultIn.ocpA) st_d.ocpA = 1'b1;
      if (faultIn.ocpB) st_d.ocpB = 1'b1;
      if (faultIn.pdfA) st_d.pdfA = 1'b1;
      if (faultIn.pdfB) st_d.pdfB = 1'b1;
      // self-clearing flags follow the condition; the undervoltage
      // flag is not writable, so a clear in sleep does nothing
      st_d.overTemp  = faultIn.overTemp;
      st_d.underVolt = faultIn.underVolt;
      // power domain: wakes with no command once the pin is high
      st_d.pumpEn = active;
      st_d.regEn  = active;
      // bridges: sleep, enable bit and faults all gate them
      st_d.bridgeA = active & st_d.control[BIT_ENABLE] & ~st_d.overTemp &
                     ~st_d.underVolt & ~st_d.ocpA & ~st_d.pdfA;
      st_d.bridgeB = active & st_d.control[BIT_ENABLE] & ~st_d.overTemp &
                     ~st_d.underVolt & ~st_d.ocpB & ~st_d.pdfB;
      st_d.faultN  = ~(st_d.overTemp | st_d.underVolt | st_d.ocpA |
                       st_d.ocpB | st_d.pdfA | st_d.pdfB);
   end

   // ---------------------------------------------------------------
   // state register; reset loads all defaults
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q         <= '0;
         st_q.control <= RST_CONTROL;
         st_q.torque  <= RST_TORQUE;
         st_q.offTime <= RST_OFFTIME;
         st_q.blank   <= RST_BLANK;
         st_q.decay   <= RST_DECAY;
         st_q.drive   <= RST_DRIVE;
         st_q.faultN  <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign chargePumpEn           = st_q.pumpEn;
   assign five_volt_regulator_en = st_q.regEn;
   assign bridgeAEn              = st_q.bridgeA;
   assign bridgeBEn              = st_q.bridgeB;
   assign faultPending_n         = st_q.faultN;
   // output driven only while awake
   assign serial_data_out_oe     = active;

   // field decode
   always_comb begin
      cfg.senseGainSel         = st_q.control[9:8];
      cfg.deadTimeSel          = st_q.control[11:10];
      cfg.torque               = st_q.torque[7:0];
      cfg.offTimeVal           = st_q.offTime[7:0];
      cfg.controlModeBit       = st_q.offTime[8];
      cfg.blankTimeVal         = st_q.blank[7:0];
      cfg.decayTransitionVal   = st_q.decay[7:0];
      cfg.decayModeSel         = st_q.decay[10:8];
      cfg.overcurrentThreshold = st_q.drive[1:0];
      cfg.overcurrentDeglitch  = st_q.drive[3:2];
      cfg.gateSinkTime         = st_q.drive[5:4];
      cfg.gateSourceTime       = st_q.drive[7:6];
      cfg.gateSinkCurrent      = st_q.drive[9:8];
      cfg.gateSourceCurrent    = st_q.drive[11:10];
      decayModeReserved = !(cfg.decayModeSel == DECAY_SLOW ||
                            cfg.decayModeSel == DECAY_FAST ||
                            cfg.decayModeSel == DECAY_MIXED ||
                            cfg.decayModeSel == DECAY_AUTO);
   end
endmodule
`default_nettype wire

/* dv/dbdcr_regs_assertions.sv */
// dbdcr_regs_assertions: port-level checker for the configuration bank.
// assumes it is bound onto dbdcr_regs and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dbdcr_regs_assertions
   import dbdcr_pkg::*;
(
   // clock and reset
   input wire logic          mclk,
   input wire logic          rst_n,
   // pins
   input wire logic          sleep_n_input,
   input wire logic          sclk,
   input wire logic          scs,
   input wire logic          serial_data_in,
   input wire logic          serial_data_out,
   input wire logic          serial_data_out_oe,
   // faults and controls
   input wire dbdcr_faults_t faultIn,
   input wire logic          chargePumpEn,
   input wire logic          five_volt_regulator_en,
   input wire logic          bridgeAEn,
   input wire logic          bridgeBEn,
   input wire logic          faultPending_n,
   input wire dbdcr_cfg_t    cfg,
   input wire logic          decayModeReserved
);
   // ----
   // assertions; sleep pin needs two sync flops plus one register
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_sleep_power: assert property (!sleep_n_input [*4] |->
      !chargePumpEn && !five_volt_regulator_en && !bridgeAEn && !bridgeBEn)
      else $error("power or bridge on while asleep");
   a_sleep_serial: assert property (!sleep_n_input [*4] |->
      !serial_data_out_oe) else $error("data out driven while asleep");
   a_wake_power: assert property (sleep_n_input [*5] |->
      chargePumpEn && five_volt_regulator_en && serial_data_out_oe)
      else $error("not awake with sleep pin high");
   a_ot_bridges: assert property (faultIn.overTemp [*4] |->
      !bridgeAEn && !bridgeBEn) else $error("bridge on in overtemp");
   a_ocp_trip: assert property (faultIn.ocpA [*2] |->
      ##[1:3] (!bridgeAEn && !faultPending_n))
      else $error("overcurrent did not stop bridge a");
   // no frame can land a write within the window, so the latch must hold
   a_pdf_latch: assert property ((!scs [*8] ##0 $fell(faultIn.pdfB)) |->
      ##2 !bridgeBEn [*8]) else $error("predriver latch let go");
   a_uv_block: assert property (faultIn.underVolt [*4] |->
      !bridgeAEn && !bridgeBEn && !faultPending_n)
      else $error("undervoltage did not block bridges");
   a_pend_cause: assert property ($fell(faultPending_n) |->
      $past(faultIn, 1) != 6'h0 || $past(faultIn, 2) != 6'h0)
      else $error("fault pin fell with no fault");
   a_cfg_quiet: assert property (!scs [*8] |=> $stable(cfg))
      else $error("config changed with no frame");
   a_reset_dflt: assert property ($rose(rst_n) |->
      cfg.torque == 8'hff && cfg.offTimeVal == 8'h30 &&
      cfg.blankTimeVal == 8'h80 && cfg.decayTransitionVal == 8'h10 &&
      cfg.senseGainSel == 2'h3) else $error("config not at defaults");
   a_decay_rsvd: assert property (decayModeReserved ==
      !(cfg.decayModeSel inside {3'h0, 3'h2, 3'h3, 3'h5}))
      else $error("reserved decay flag wrong");

   // main scenarios
   c_sleep: cover property (!sleep_n_input [*4]);
   c_ocp: cover property ($fell(faultIn.ocpA));
   c_frame: cover property ($fell(scs));
endmodule

bind dbdcr_regs dbdcr_regs_assertions u_chk (
   .mclk                   (mclk),
   .rst_n                  (rst_n),
   .sleep_n_input          (sleep_n_input),
   .sclk                   (sclk),
   .scs                    (scs),
   .serial_data_in         (serial_data_in),
   .serial_data_out        (serial_data_out),
   .serial_data_out_oe     (serial_data_out_oe),
   .faultIn                (faultIn),
   .chargePumpEn           (chargePumpEn),
   .five_volt_regulator_en (five_volt_regulator_en),
   .bridgeAEn              (bridgeAEn),
   .bridgeBEn              (bridgeBEn),
   .faultPending_n         (faultPending_n),
   .cfg                    (cfg),
   .decayModeReserved      (decayModeReserved)
);
`default_nettype wire

/* dv/dbdcr_host_model.sv */
// dbdcr_host_model: serial host that frames requests to the bank.
// assumes the bench calls xfer and feeds back the resolved data-out line.
`timescale 1ns/10ps
`default_nettype none
module dbdcr_host_model (
   // link pins toward the bank
   output var logic sclk,
   output var logic scs,
   output var logic sdi,
   // resolved data-out line
   input  wire logic sdoLine
);
   localparam int HalfNs = 80;   // half of the 160 ns link period

   // link clock stands still outside frames
   initial begin
      sclk = 1'b0;
      scs  = 1'b0;
      sdi  = 1'b0;
   end

   // one frame; nBits other than 16 only when a refusal is wanted
   task automatic xfer(input logic rd, input logic [2:0] a,
                       input logic [11:0] d, input int nBits,
                       output logic [11:0] q);
      logic [15:0] f;
      f = {rd, a, d};
      q = 12'h0;
      scs = 1'b1;
      #HalfNs;
      for (int i = 0; i < nBits; i++) begin
         sdi = f[15 - i];
         #HalfNs sclk = 1'b1;
         if (i > 3) q = {q[10:0], sdoLine};
         #HalfNs sclk = 1'b0;
      end
      #HalfNs scs = 1'b0;
      sdi = ~sdi;   // released line must not look like held data
      #200;
   endtask
endmodule
`default_nettype wire

/* dv/dbdcr_regs_tb_top.sv */
// dbdcr_regs_tb_top: self-checking bench for the configuration bank.
// assumes dbdcr_host_model as serial host and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module dbdcr_regs_tb_top;
   import dbdcr_pkg::*;
   // ----
   // signals and model state
   // ----
   logic          mclk, rst_n, sleepN, sclk, scs, sdi, sdo, sdoOe;
   logic          pumpEn, ldoEn, brA, brB, pendN, dmRsvd;
   logic          idleTog = 1'b0;
   wire logic     sdoLine;
   dbdcr_faults_t faults;
   dbdcr_cfg_t    cfg;
   logic [11:0]   m [8];   // behavioural register image
   logic [11:0]   q, d;
   int            err_total, comparisons, cyc, seed;

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // undriven data-out toggles so a stale bit never reads back
   always @(posedge mclk) idleTog <= ~idleTog;
   assign sdoLine = sdoOe ? sdo : idleTog;

   dbdcr_regs DUT (.mclk(mclk), .rst_n(rst_n), .sleep_n_input(sleepN),
      .sclk(sclk), .scs(scs), .serial_data_in(sdi), .serial_data_out(sdo),
      .serial_data_out_oe(sdoOe), .faultIn(faults), .chargePumpEn(pumpEn),
      .five_volt_regulator_en(ldoEn), .bridgeAEn(brA), .bridgeBEn(brB),
      .faultPending_n(pendN), .cfg(cfg), .decayModeReserved(dmRsvd));
   dbdcr_host_model host (.sclk(sclk), .scs(scs), .sdi(sdi),
      .sdoLine(sdoLine));

   // ----
   // helpers
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [11:0] wmask(input logic [2:0] a);
      case (a)
         ADDR_CONTROL: return MASK_CONTROL;
         ADDR_TORQUE:  return MASK_TORQUE;
         ADDR_OFFTIME: return MASK_OFFTIME;
         ADDR_BLANK:   return MASK_BLANK;
         ADDR_DECAY:   return MASK_DECAY;
         ADDR_DRIVE:   return MASK_DRIVE;
         default:      return 12'h0;   // spare slot; flags handled apart
      endcase
   endfunction
   function automatic dbdcr_cfg_t cfgExp();
      return {m[0][9:8], m[0][11:10], m[1][7:0], m[2][7:0], m[2][8],
              m[3][7:0], m[4][7:0], m[4][10:8], m[6][1:0], m[6][3:2],
              m[6][5:4], m[6][7:6], m[6][9:8], m[6][11:10]};
   endfunction
   // bridge on only when enabled and free of own and global faults
   function automatic logic brExp(input int ch);
      return m[0][0] & ~m[7][0] & ~m[7][5] & ~m[7][1+ch] & ~m[7][3+ch];
   endfunction
   task automatic wr(input logic [2:0] a, input logic [11:0] v);
      if (a == ADDR_OFFTIME) v[8] = 1'b1;
      host.xfer(1'b0, a, v, 16, q);
      m[a] = (m[a] & ~wmask(a)) | (v & wmask(a));
      if (a == ADDR_FAULTS) m[a][4:1] = m[a][4:1] & v[4:1];
      tick(1);
   endtask
   // junk data after the address must be ignored
   task automatic rd(input logic [2:0] a);
      d = 12'($urandom);
      host.xfer(1'b1, a, d, 16, q);
      check("read", q, m[a]);
      tick(1);
   endtask

   // hang guard, well above the expected run length
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         finish_test();
      end
   end

   // ----
   // main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      sleepN = 1'b1;
      faults = '0;
      seed = $urandom(32'hf33b989d);
      m = '{RST_CONTROL, RST_TORQUE, RST_OFFTIME, RST_BLANK, RST_DECAY,
            12'h0, RST_DRIVE, 12'h0};
      tick(6);
      rst_n = 1'b1;
      tick(6);
      for (int a = 0; a < 8; a++) rd(3'(a));
      check("cfg", cfg, cfgExp());
      check("power", {pumpEn, ldoEn, sdoOe}, 3'h7);
      // random fields in every register but the flags, which are written zero; every decay code once
      for (int r = 0; r < 8; r++) begin
         for (int a = 0; a < 8; a++) begin
            d = 12'($urandom);
            if (a == 4) d[10:8] = 3'(r);
            if (a == 7) d = 12'h0;
            wr(3'(a), d);
            rd(3'(a));
         end
         check("cfg", cfg, cfgExp());
         check("dmRsvd", dmRsvd, !(m[4][10:8] inside {0, 2, 3, 5}));
         check("bridgeA", brA, brExp(0));
      end
      wr(ADDR_CONTROL, 12'h300);
      check("disabled", {brA, brB, pumpEn, sdoOe}, 4'h3);
      wr(ADDR_CONTROL, 12'h301);
      host.xfer(1'b0, ADDR_TORQUE, 12'h05a, 15, q);
      tick(1);
      rd(ADDR_TORQUE);
      // each fault source in turn
      for (int k = 0; k < 6; k++) begin
         faults[5-k] = 1'b1;
         tick(10);
         m[7][k] = 1'b1;
         rd(ADDR_FAULTS);
         check("bridges", {brA, brB, pendN}, {brExp(0), brExp(1), 1'b0});
         faults[5-k] = 1'b0;
         tick(10);
         if (k == 0 || k == 5) m[7][k] = 1'b0;
         rd(ADDR_FAULTS);
         check("held", {brA, brB}, {brExp(0), brExp(1)});
         wr(ADDR_FAULTS, 12'h0);
         rd(ADDR_FAULTS);
         check("cleared", {brA, brB, pendN}, 3'h7);
      end
      // sleep with undervoltage standing; frames must be ignored
      faults.underVolt = 1'b1;
      tick(10);
      m[7][5] = 1'b1;
      sleepN = 1'b0;
      tick(10);
      check("asleep", {pumpEn, ldoEn, brA, brB, sdoOe}, 5'h0);
      host.xfer(1'b0, ADDR_FAULTS, 12'h0, 16, q);
      host.xfer(1'b0, ADDR_TORQUE, 12'h0, 16, q);
      tick(1);
      sleepN = 1'b1;
      tick(10);
      check("awake", {pumpEn, ldoEn, sdoOe}, 3'h7);
      rd(ADDR_TORQUE);
      rd(ADDR_FAULTS);
      faults.underVolt = 1'b0;
      tick(10);
      m[7][5] = 1'b0;
      rd(ADDR_FAULTS);
      check("bridgeA", brA, brExp(0));
      finish_test();
   end
endmodule
`default_nettype wire
